// ==== shared/iodp_cfg.svh ====
`ifndef IODP_CFG_SVH
`define IODP_CFG_SVH

// register offsets within the board's four-byte window
`define IODP_OFS_OUT 2'h0
`define IODP_OFS_IN 2'h1
`define IODP_OFS_LINE 2'h2
`define IODP_OFS_CTRL 2'h3

// control byte: bit 7 set means a configuration write
`define IODP_CTRL_CFG_BIT 7
`define IODP_CTRL_RST 8'h82

// line byte: bits 3..1 line index, bit 0 line value
`define IODP_LINE_IDX_HI 3
`define IODP_LINE_IDX_LO 1
`define IODP_LINE_VAL_BIT 0

`define IODP_OUT_RST 8'h00
`define IODP_BASE_DFLT 10'h200

`endif

// ==== shared/iodp_pkg.sv ====
package iodp_pkg;

	typedef enum logic [2:0] {
		IODP_IDLE = 3'b001,
		IODP_WR = 3'b010,
		IODP_RD = 3'b100
	} iodp_state_t;

	typedef struct packed {
		logic aen;
		logic [9:0] addr;
		logic rd_n;
		logic wr_n;
		logic [7:0] data;
	} iodp_host_t;

endpackage

// ==== logic/iodp_port_pair.sv ====
// Functional notes
// - board enable only on own address
// - data buffers face host on read
// - two byte ports: eight in, eight out
// - first port output, second input, third single line access
// - isolated inputs read back inverted
// - configuration write zeroes the output port
// - byte write, single line write, line read
`timescale 1ns/10ps
`default_nettype none
`include "iodp_cfg.svh"

module iodp_port_pair
	import iodp_pkg::*;
#(
	parameter int ADDR_W = 10,
	parameter logic [9:0] BASE_ADDR = `IODP_BASE_DFLT
) (
	input wire logic CORE_CLK_IN,
	input wire logic RESET_IN,
	input wire logic CE_IN,
	input wire iodp_host_t HOST_BUS_IN,
	input wire logic [7:0] ISOLATED_INPUT_PIN_IN,
	output logic BOARD_EN_OUT,
	output logic DATA_DIR_OUT,
	output logic DATA_OE_OUT,
	output logic [7:0] DATA_OUT,
	output logic [7:0] ISOLATED_OUTPUT_PIN_OUT,
	output logic [7:0] CONFIG_OUT
);

	// decode is built for exactly ten host address bits
	if (ADDR_W != 10) begin : g_addr_w_check
		$error("iodp_port_pair: host address must be 10 bits");
	end

	// low two bits pick the offset, so the base must sit on a boundary
	if (BASE_ADDR[1:0] != 2'h0) begin : g_base_check
		$error("iodp_port_pair: base address must be 4-byte aligned");
	end

	function automatic logic [7:0] line_mask(input logic [2:0] idx);
		line_mask = 8'h01 << idx;
	endfunction

	function automatic logic [2:0] line_index(input logic [7:0] b);
		line_index = b[`IODP_LINE_IDX_HI:`IODP_LINE_IDX_LO];
	endfunction

	iodp_state_t state;
	iodp_state_t next_state;
	logic [7:0] out_port;
	logic [7:0] next_out_port;
	logic [7:0] ctrl;
	logic [7:0] next_ctrl;
	logic [2:0] line_idx;
	logic [2:0] next_line_idx;
	logic [7:0] rd_data;
	logic [7:0] next_rd_data;
	logic sel;
	logic wr_take;
	logic rd_take;
	logic [1:0] ofs;
	logic [7:0] in_port;
	logic [7:0] wdata;

	// upper address bits pick the board; AEN high marks a DMA cycle
	always_comb begin
		sel = !HOST_BUS_IN.aen &&
			(HOST_BUS_IN.addr[9:2] == BASE_ADDR[9:2]);
	end

	assign BOARD_EN_OUT = sel;
	assign ofs = HOST_BUS_IN.addr[1:0];
	assign wdata = HOST_BUS_IN.data;
	// receivers invert the coupler levels
	assign in_port = ~ISOLATED_INPUT_PIN_IN;

	// one access per strobe: a held strobe is taken only once
	always_comb begin
		wr_take = 1'b0;
		rd_take = 1'b0;
		next_state = state;
		unique case (state)
			IODP_IDLE: begin
				if (sel && !HOST_BUS_IN.wr_n) begin
					wr_take = 1'b1;
					next_state = IODP_WR;
				end else if (sel && !HOST_BUS_IN.rd_n) begin
					rd_take = 1'b1;
					next_state = IODP_RD;
				end
			end
			IODP_WR: begin
				if (HOST_BUS_IN.wr_n) begin
					next_state = IODP_IDLE;
				end
			end
			IODP_RD: begin
				if (HOST_BUS_IN.rd_n || !sel) begin
					next_state = IODP_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (RESET_IN) begin
			state <= IODP_IDLE;
		end else if (CE_IN) begin
			state <= next_state;
		end
	end

	// buffers turn toward the host only while a read is served
	assign DATA_DIR_OUT = (state == IODP_RD);
	assign DATA_OE_OUT = (state == IODP_RD);

	// output port: byte write, single line write, cleared on config
	always_comb begin
		next_out_port = out_port;
		if (wr_take) begin
			unique case (ofs)
				`IODP_OFS_OUT: begin
					next_out_port = wdata;
				end
				`IODP_OFS_LINE: begin
					if (wdata[`IODP_LINE_VAL_BIT]) begin
						next_out_port = out_port |
							line_mask(line_index(wdata));
					end else begin
						next_out_port = out_port &
							~line_mask(line_index(wdata));
					end
				end
				`IODP_OFS_CTRL: begin
					if (wdata[`IODP_CTRL_CFG_BIT]) begin
						next_out_port = `IODP_OUT_RST;
					end
				end
				`IODP_OFS_IN: begin
					next_out_port = out_port;
				end
			endcase
		end
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (RESET_IN) begin
			out_port <= `IODP_OUT_RST;
		end else if (CE_IN) begin
			out_port <= next_out_port;
		end
	end

	assign ISOLATED_OUTPUT_PIN_OUT = out_port;

	// control byte is kept for read-back only; port roles are fixed
	always_comb begin
		next_ctrl = ctrl;
		if (wr_take && ofs == `IODP_OFS_CTRL &&
			wdata[`IODP_CTRL_CFG_BIT]) begin
			next_ctrl = wdata;
		end
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (RESET_IN) begin
			ctrl <= `IODP_CTRL_RST;
		end else if (CE_IN) begin
			ctrl <= next_ctrl;
		end
	end

	assign CONFIG_OUT = ctrl;

	// last line written also picks the line that a line read returns
	always_comb begin
		next_line_idx = line_idx;
		if (wr_take && ofs == `IODP_OFS_LINE) begin
			next_line_idx = line_index(wdata);
		end
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (RESET_IN) begin
			line_idx <= 3'h0;
		end else if (CE_IN) begin
			line_idx <= next_line_idx;
		end
	end

	// read data is caught once at the strobe and held for the cycle
	always_comb begin
		next_rd_data = rd_data;
		if (rd_take) begin
			unique case (ofs)
				`IODP_OFS_OUT: begin
					next_rd_data = out_port;
				end
				`IODP_OFS_IN: begin
					next_rd_data = in_port;
				end
				`IODP_OFS_LINE: begin
					next_rd_data = {7'h00, in_port[line_idx]};
				end
				`IODP_OFS_CTRL: begin
					next_rd_data = ctrl;
				end
			endcase
		end
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (RESET_IN) begin
			rd_data <= 8'h00;
		end else if (CE_IN) begin
			rd_data <= next_rd_data;
		end
	end

	assign DATA_OUT = rd_data;

endmodule

`default_nettype wire

// ==== bench/iodp_props.sv ====
`timescale 1ns/10ps
`default_nettype none
module iodp_props
	import iodp_pkg::*;
#(parameter logic [9:0] BASE_ADDR = 10'h200) (
	input wire logic CORE_CLK_IN,
	input wire logic RESET_IN,
	input wire logic CE_IN,
	input wire iodp_host_t HOST_BUS_IN,
	input wire logic [7:0] ISOLATED_INPUT_PIN_IN,
	input wire logic BOARD_EN_OUT,
	input wire logic DATA_DIR_OUT,
	input wire logic DATA_OE_OUT,
	input wire logic [7:0] DATA_OUT,
	input wire logic [7:0] ISOLATED_OUTPUT_PIN_OUT,
	input wire logic [7:0] CONFIG_OUT
);
default clocking @(posedge CORE_CLK_IN); endclocking
default disable iff (RESET_IN);
wire iodp_host_t h = HOST_BUS_IN;
wire [1:0] o = h.addr[1:0];
wire [7:0] p = ISOLATED_OUTPUT_PIN_OUT;
// a strobe counts only while no read is served, selected and running
wire go = BOARD_EN_OUT && CE_IN && !DATA_DIR_OUT;
sequence s_wr;
	go && !h.wr_n;
endsequence
sequence s_rd;
	go && h.wr_n && !h.rd_n;
endsequence
chk_bus_sel: assert property (
	BOARD_EN_OUT == (!h.aen && h.addr[9:2] == BASE_ADDR[9:2]))
	else $error("select");
chk_rd_dir: assert property (
	s_rd |=> DATA_DIR_OUT && DATA_OE_OUT) else $error("direction");
chk_wr_dir: assert property (
	s_wr |=> !DATA_DIR_OUT && !DATA_OE_OUT) else $error("write direction");
chk_rd_end: assert property (
	DATA_DIR_OUT && CE_IN && h.rd_n |=> !DATA_DIR_OUT && !DATA_OE_OUT)
	else $error("read end");
chk_ce_hold: assert property (
	!CE_IN |=> $stable(p) && $stable(DATA_OUT) && $stable(CONFIG_OUT))
	else $error("enable");
chk_out_byte: assert property (
	s_wr ##0 o == 2'h0 |=> p == $past(h.data)) else $error("byte");
chk_out_line: assert property (
	s_wr ##0 o == 2'h2 |=> p[$past(h.data[3:1])] == $past(h.data[0]))
	else $error("line");
chk_in_inv: assert property (
	s_rd ##0 o == 2'h1 |=> DATA_OUT == ~$past(ISOLATED_INPUT_PIN_IN))
	else $error("input");
chk_cfg_clr: assert property (
	s_wr ##0 o == 2'h3 && h.data[7] |=>
	p == 8'h00 && CONFIG_OUT == $past(h.data))
	else $error("config");
chk_in_ro: assert property (s_wr ##0 o == 2'h1 |=> $stable(p))
	else $error("readonly");
chk_rst_zero: assert property (
	disable iff (1'b0) RESET_IN |=> p == 8'h00 && !DATA_DIR_OUT &&
	CONFIG_OUT == 8'h82 && DATA_OUT == 8'h00)
	else $error("reset");
endmodule
bind iodp_port_pair iodp_props #(.BASE_ADDR(BASE_ADDR)) i_props (
	.CORE_CLK_IN(CORE_CLK_IN),
	.RESET_IN(RESET_IN),
	.CE_IN(CE_IN),
	.HOST_BUS_IN(HOST_BUS_IN),
	.ISOLATED_INPUT_PIN_IN(ISOLATED_INPUT_PIN_IN),
	.BOARD_EN_OUT(BOARD_EN_OUT),
	.DATA_DIR_OUT(DATA_DIR_OUT),
	.DATA_OE_OUT(DATA_OE_OUT),
	.DATA_OUT(DATA_OUT),
	.ISOLATED_OUTPUT_PIN_OUT(ISOLATED_OUTPUT_PIN_OUT),
	.CONFIG_OUT(CONFIG_OUT)
);
`default_nettype wire

// ==== bench/iodp_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module iodp_host_model
	import iodp_pkg::*;
(
	input wire logic clk_in,
	input wire logic oe_in,
	input wire logic [7:0] data_in,
	output var iodp_host_t bus_out
);
initial bus_out = '{1'b1, 10'h000, 1'b1, 1'b1, 8'h00};
// released data is flipped so a stale bus cannot pass
task automatic acc(logic w, logic [9:0] a, logic [7:0] d,
	output logic [7:0] q);
	int n = 0;
	bus_out <= '{1'b0, a, w, !w, d};
	@(posedge clk_in);
	while (!w && !oe_in && n++ < 4) @(posedge clk_in);
	// a read whose buffers never turned hands back unknown data
	q = (w || oe_in) ? data_in : 8'hxx;
	bus_out <= '{1'b0, a, 1'b1, 1'b1, ~d};
	@(posedge clk_in);
endtask
// dma cycle: address and strobe valid, but the board must stay off
task automatic dma_wr(logic [9:0] a, logic [7:0] d);
	bus_out <= '{1'b1, a, 1'b1, 1'b0, d};
	@(posedge clk_in);
	bus_out <= '{1'b1, a, 1'b1, 1'b1, ~d};
	@(posedge clk_in);
endtask
endmodule
`default_nettype wire

// ==== bench/isolated_dio_port_pair_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module isolated_dio_port_pair_test;
localparam logic [9:0] B = 10'h200;
logic clk = 1'b0;
logic rst = 1'b1;
logic [7:0] pin = 8'h00;
logic ce = 1'b1;
logic oe;
logic [7:0] rd, po, cfg, q;
iodp_pkg::iodp_host_t bus;
int miscompares = 0;
int cmp_count = 0;
int cyc = 0;
initial forever #2 clk = ~clk;
iodp_port_pair #(.BASE_ADDR(B)) i_dut (.CORE_CLK_IN(clk), .RESET_IN(rst),
	.CE_IN(ce), .HOST_BUS_IN(bus), .ISOLATED_INPUT_PIN_IN(pin),
	.BOARD_EN_OUT(), .DATA_DIR_OUT(), .DATA_OE_OUT(oe), .DATA_OUT(rd),
	.ISOLATED_OUTPUT_PIN_OUT(po), .CONFIG_OUT(cfg));
iodp_host_model i_h (.clk_in(clk), .oe_in(oe), .data_in(rd),
	.bus_out(bus));
task chk(input logic [7:0] g, e);
	cmp_count++;
	if (g !== e) begin
		miscompares++;
		$display("MISMATCH %0t %h %h", $time, g, e);
	end
endtask
task tally_and_finish;
	$display("compares %0d mismatches %0d", cmp_count, miscompares);
	if (miscompares == 0 && cmp_count > 0) $display("RESULT: PASS");
	else $display("RESULT: FAIL");
	$finish;
endtask
always @(posedge clk) begin
	if (++cyc == 2000) begin
		miscompares++;
		tally_and_finish;
	end
end
task wr(input logic [9:0] a, input logic [7:0] d);
	i_h.acc(1'b1, a, d, q);
endtask
task t_rst;
	rst <= 1'b1;
	repeat (5) @(posedge clk);
	rst <= 1'b0;
	@(posedge clk);
	chk(po, 8'h00);
	chk(cfg, 8'h82);
endtask
task t_port;
	wr(B + 10'h3, 8'h80);
	wr(B, 8'hf0);
	chk(po, 8'hf0);
	i_h.acc(1'b0, B, 8'h00, q);
	chk(q, 8'hf0);
	wr(B + 10'h2, 8'h08);
	chk(po, 8'he0);
	pin <= 8'h5a;
	i_h.acc(1'b0, B + 10'h2, 8'h00, q);
	chk(q, 8'h00);
	i_h.acc(1'b0, B + 10'h1, 8'h00, q);
	chk(q, 8'ha5);
	wr(B + 10'h1, 8'h33);
	chk(po, 8'he0);
	wr(B + 10'h2, 8'h01);
	chk(po, 8'he1);
	i_h.acc(1'b0, B + 10'h2, 8'h00, q);
	chk(q, 8'h01);
endtask
task t_cfg;
	wr(B + 10'h3, 8'h1b);
	chk(cfg, 8'h80);
	chk(po, 8'he1);
	wr(B + 10'h3, 8'h9b);
	chk(po, 8'h00);
	chk(cfg, 8'h9b);
	i_h.acc(1'b0, B + 10'h3, 8'h00, q);
	chk(q, 8'h9b);
endtask
task t_sel;
	wr(B, 8'h3c);
	wr(10'h300, 8'hff);
	wr(B + 10'h4, 8'hc3);
	i_h.dma_wr(B, 8'h99);
	chk(po, 8'h3c);
endtask
task t_ce;
	ce <= 1'b0;
	wr(B, 8'h55);
	ce <= 1'b1;
	chk(po, 8'h3c);
	wr(B, 8'h55);
	chk(po, 8'h55);
endtask
initial begin
	t_rst;
	t_port;
	t_cfg;
	t_sel;
	t_ce;
	t_rst;
	tally_and_finish;
end
endmodule
`default_nettype wire
